// [design/acr_i2c_slave.sv]
// serial bus slave and register logic of the 12-bit converter
`timescale 1ns/1ps
`include "acr_defs.svh"

module acr_i2c_slave #(
	parameter int unsigned ADDR_SEL = 0
) (
	input  wire logic                   core_clk,
	input  wire logic                   sys_rst,
	input  wire logic                   sclClk,
	input  wire logic                   sclIn,
	input  wire logic                   sdaIn,
	output logic                        sdaOut,
	output logic                        sdaOeN,
	output logic                        hsFilterEn,
	output logic                        convStart,
	output logic                        convAbort,
	output logic                        contMode,
	output acr_pkg::acr_gain_t          gainSel,
	input  wire logic                   convDone,
	input  wire logic [`ACR_DATA_W-1:0] convData
);
	import acr_pkg::*;

	// ----------------------------------------------------------------
	// parameters and elaboration checks
	// ----------------------------------------------------------------
	localparam logic [6:0] MY_ADDR = (ADDR_SEL == 0) ? `ACR_ADDR_BASE : `ACR_ADDR_ALT;
	localparam int HS_HIGH_CYC = `ACR_HS_THIGH_NS / `ACR_CLK_PERIOD_NS;

	// the shortest fast-mode clock high must outlast the synchroniser delay
	generate
		if (ADDR_SEL > 1) begin : g_bad_addr
			$error("ADDR_SEL must be 0 or 1");
		end
		if (HS_HIGH_CYC < `ACR_SYNC_LAT_CYC) begin : g_bad_clk
			$error("core clock too slow for fast-mode bus clock");
		end
	endgenerate

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	function automatic logic [15:0] signExt(input logic [`ACR_DATA_W-1:0] d);
		signExt = {{`ACR_SIGN_BITS{d[`ACR_DATA_W-1]}}, d};
	endfunction

	// reserved bits always read zero
	function automatic logic [7:0] cfgView(
		input logic      single,
		input logic      busy,
		input acr_gain_t gain
	);
		logic [7:0] v;
		v = '0;
		v[`ACR_CFG_BUSY] = single ? busy : 1'b1;
		v[`ACR_CFG_SINGLE] = single;
		v[`ACR_CFG_GAIN_HI:`ACR_CFG_GAIN_LO] = gain;
		cfgView = v;
	endfunction

	// byte served at each position of a read
	function automatic logic [7:0] readByte(
		input logic [1:0]  idx,
		input logic [15:0] res,
		input logic [7:0]  cfg
	);
		case (idx)
			`ACR_IDX_MSB: readByte = res[`ACR_RES_HI_BYTE];
			`ACR_IDX_LSB: readByte = res[`ACR_RES_LO_BYTE];
			`ACR_IDX_CFG: readByte = cfg;
			default:      readByte = `ACR_FILL_BYTE;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state, link capture and bus events
	// ----------------------------------------------------------------
	acr_core_t core_ff;
	acr_core_t nxt_core;
	logic      bitVal;
	logic      bitTgl;
	logic      startEv;
	logic      stopEv;
	logic      sclFall;
	logic      protoBit;
	logic      byteDone;
	logic      ackSlot;
	logic      wrCfg;
	logic [7:0] byteIn;
	logic [7:0] cfgRd;

	acr_scl_capture u_cap (
		.sclClk (sclClk),
		.sys_rst(sys_rst),
		.sdaIn  (sdaIn),
		.bitVal (bitVal),
		.bitTgl (bitTgl)
	);

	// start and stop seen only while the clock is high on both samples
	assign startEv  = core_ff.sclS2 & core_ff.sclPrev & core_ff.sdaPrev & ~core_ff.sdaS2;
	assign stopEv   = core_ff.sclS2 & core_ff.sclPrev & ~core_ff.sdaPrev & core_ff.sdaS2;
	assign sclFall  = core_ff.sclPrev & ~core_ff.sclS2;
	assign protoBit = (core_ff.tglS2 ^ core_ff.tglPrev) & ~startEv & ~stopEv
		& (core_ff.st != ST_IDLE);
	assign byteDone = protoBit & (core_ff.bitCnt == `ACR_LAST_DATA_BIT);
	assign ackSlot  = protoBit & (core_ff.bitCnt == `ACR_ACK_SLOT);
	assign byteIn   = {core_ff.shReg[6:0], bitVal};
	assign wrCfg    = byteDone & (core_ff.st == ST_WRITE) & ~core_ff.wrDone;
	assign cfgRd    = cfgView(core_ff.single, core_ff.busy, core_ff.gain);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		nxt_core = core_ff;
		// two-stage synchronisers, first stage read only by the second
		nxt_core.sclS1   = sclIn;
		nxt_core.sclS2   = core_ff.sclS1;
		nxt_core.sclPrev = core_ff.sclS2;
		nxt_core.sdaS1   = sdaIn;
		nxt_core.sdaS2   = core_ff.sdaS1;
		nxt_core.sdaPrev = core_ff.sdaS2;
		nxt_core.tglS1   = bitTgl;
		nxt_core.tglS2   = core_ff.tglS1;
		nxt_core.tglPrev = core_ff.tglS2;
		nxt_core.convStart = 1'b0;
		nxt_core.convAbort = 1'b0;

		// finished conversion; a stray finish in idle single mode is dropped
		if (convDone && (!core_ff.single || core_ff.busy)) begin
			nxt_core.result = signExt(convData);
			nxt_core.busy   = 1'b0;
		end

		if (startEv) begin
			// plain and repeated start; normal rates need nothing else
			nxt_core.st     = ST_ADDR;
			nxt_core.bitCnt = '0;
			nxt_core.ackNow = 1'b0;
			nxt_core.drvLow = 1'b0;
		end else if (stopEv) begin
			nxt_core.st     = ST_IDLE;
			nxt_core.hsMode = 1'b0;
			nxt_core.bitCnt = '0;
			nxt_core.ackNow = 1'b0;
			nxt_core.drvLow = 1'b0;
			nxt_core.gcHit  = 1'b0;
		end else begin
			if (ackSlot) begin
				// ninth clock: ours or the master's acknowledge
				nxt_core.bitCnt = '0;
				nxt_core.ackNow = 1'b0;
				if (core_ff.gcHit) begin
					// full reset: abort, zero result, default config
					nxt_core.gcHit     = 1'b0;
					nxt_core.result    = `ACR_RESULT_RESET;
					nxt_core.single    = 1'b0;
					nxt_core.gain      = `ACR_GAIN_RESET;
					nxt_core.busy      = 1'b0;
					nxt_core.convAbort = 1'b1;
				end
				if (core_ff.st == ST_READ) begin
					if (core_ff.rdFirst) begin
						nxt_core.rdFirst = 1'b0;
						nxt_core.txReg   = readByte(`ACR_IDX_MSB, core_ff.result, cfgRd);
					end else if (!bitVal) begin
						// master acked: next byte, saturating on the fill byte
						if (core_ff.rdIdx != `ACR_IDX_FILL) begin
							nxt_core.rdIdx = core_ff.rdIdx + 2'h1;
							nxt_core.txReg = readByte(core_ff.rdIdx + 2'h1, core_ff.result,
								cfgRd);
						end else begin
							nxt_core.txReg = `ACR_FILL_BYTE;
						end
					end else begin
						nxt_core.st = ST_SKIP;
					end
				end
			end else if (protoBit) begin
				nxt_core.shReg  = byteIn;
				nxt_core.txReg  = {core_ff.txReg[6:0], 1'b1};
				nxt_core.bitCnt = core_ff.bitCnt + 4'h1;
			end

			if (byteDone) begin
				unique case (core_ff.st)
					ST_ADDR: begin
						if (byteIn[`ACR_MCODE_FIELD] == `ACR_MCODE_HI) begin
							// master code: low bit carries no direction
							nxt_core.ackNow = 1'b1;
							nxt_core.hsMode = 1'b1;
							nxt_core.st     = ST_SKIP;
						end else if (byteIn[`ACR_ADDR_FIELD] == MY_ADDR) begin
							nxt_core.ackNow  = 1'b1;
							nxt_core.rdFirst = byteIn[`ACR_RW_BIT];
							nxt_core.rdIdx   = `ACR_IDX_MSB;
							nxt_core.wrDone  = 1'b0;
							nxt_core.st      = byteIn[`ACR_RW_BIT] ? ST_READ : ST_WRITE;
						end else if (byteIn == `ACR_GC_ADDR) begin
							nxt_core.ackNow = 1'b1;
							nxt_core.st     = ST_GCALL;
						end else begin
							nxt_core.st = ST_SKIP;
						end
					end
					ST_WRITE: begin
						if (!core_ff.wrDone) begin
							// reserved bits are dropped, result never written
							nxt_core.ackNow = 1'b1;
							nxt_core.wrDone = 1'b1;
							nxt_core.single = byteIn[`ACR_CFG_SINGLE];
							nxt_core.gain   = byteIn[`ACR_CFG_GAIN_HI:`ACR_CFG_GAIN_LO];
							if (byteIn[`ACR_CFG_SINGLE]) begin
								if (byteIn[`ACR_CFG_BUSY]) begin
									// set wins over a finish in the same cycle
									nxt_core.busy      = 1'b1;
									nxt_core.convStart = 1'b1;
								end
							end else begin
								nxt_core.busy = 1'b0;
							end
						end else begin
							nxt_core.ackNow = 1'b0;
						end
					end
					ST_GCALL: begin
						nxt_core.st = ST_SKIP;
						if (byteIn == `ACR_GC_RESET) begin
							nxt_core.ackNow = 1'b1;
							nxt_core.gcHit  = 1'b1;
						end else if (byteIn == `ACR_GC_LATCH) begin
							nxt_core.ackNow = 1'b1;
						end
					end
					ST_IDLE, ST_READ, ST_SKIP: begin
					end
				endcase
			end

			// data line only changes just after the clock falls
			if (sclFall) begin
				nxt_core.drvLow = ((core_ff.bitCnt == `ACR_ACK_SLOT) & core_ff.ackNow)
					| ((core_ff.st == ST_READ) & ~core_ff.rdFirst
					& (core_ff.bitCnt < `ACR_ACK_SLOT) & ~core_ff.txReg[7]);
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// all-zero reset gives idle, continuous mode, gain 1, result zero: reads 80H
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			core_ff <= '0;
		end else begin
			core_ff <= nxt_core;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// open drain: only ever pulls low, and no clock output exists at all
	assign sdaOut     = 1'b0;
	assign sdaOeN     = ~core_ff.drvLow;
	assign hsFilterEn = core_ff.hsMode;
	assign convStart  = core_ff.convStart;
	assign convAbort  = core_ff.convAbort;
	assign contMode   = ~core_ff.single;
	assign gainSel    = core_ff.gain;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	mcode_ack_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(byteDone && core_ff.st == ST_ADDR && byteIn[`ACR_MCODE_FIELD] == `ACR_MCODE_HI)
		|=> (core_ff.ackNow && core_ff.hsMode && core_ff.st == ST_SKIP))
		else $error("master code not acknowledged");

	hs_exit_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		stopEv |=> (!hsFilterEn && core_ff.st == ST_IDLE))
		else $error("fast mode kept after stop");

	sign_ext_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		core_ff.result[15:12] == {`ACR_SIGN_BITS{core_ff.result[11]}})
		else $error("result not sign extended");
	cont_busy_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(contMode && ackSlot && core_ff.st == ST_READ && !core_ff.rdFirst && !bitVal
		&& core_ff.rdIdx == `ACR_IDX_LSB) |=> core_ff.txReg[`ACR_CFG_BUSY])
		else $error("busy bit not one in continuous mode");
	single_busy_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(!contMode && convDone && core_ff.busy && !wrCfg && !(ackSlot && core_ff.gcHit))
		|=> !cfgRd[`ACR_CFG_BUSY])
		else $error("busy bit not cleared at conversion end");

	start_conv_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(wrCfg && byteIn[`ACR_CFG_SINGLE] && byteIn[`ACR_CFG_BUSY])
		|=> (convStart && core_ff.busy) ##1 !convStart)
		else $error("single start write did not start");

	cont_ignore_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(wrCfg && !byteIn[`ACR_CFG_SINGLE]) |=> (!convStart && contMode))
		else $error("start honoured in continuous mode");

	done_load_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(convDone && core_ff.busy && !wrCfg && !(ackSlot && core_ff.gcHit))
		|=> (!core_ff.busy && core_ff.result == signExt($past(convData))))
		else $error("result and busy not updated together");

	gc_reset_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(ackSlot && core_ff.gcHit)
		|=> (convAbort && core_ff.result == `ACR_RESULT_RESET && cfgRd == `ACR_CFG_RESET))
		else $error("general call reset incomplete");

	extra_nack_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(byteDone && core_ff.st == ST_WRITE && core_ff.wrDone)
		|=> !core_ff.ackNow [*2])
		else $error("extra write byte acknowledged");

	fill_byte_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(ackSlot && core_ff.st == ST_READ && !core_ff.rdFirst && !bitVal
		&& core_ff.rdIdx >= `ACR_IDX_CFG)
		|=> (core_ff.txReg == `ACR_FILL_BYTE && core_ff.rdIdx == `ACR_IDX_FILL))
		else $error("fourth read byte not FFh");

	ack_drive_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(sclFall && core_ff.ackNow && core_ff.bitCnt == `ACR_ACK_SLOT && !startEv && !stopEv)
		|=> !sdaOeN)
		else $error("acknowledge not driven");

endmodule

// [design/acr_scl_capture.sv]
// bit capture on the bus clock: samples data at each rising clock edge, flags it by toggle
`timescale 1ns/1ps

module acr_scl_capture (
	input  wire logic sclClk,
	input  wire logic sys_rst,
	input  wire logic sdaIn,
	output logic      bitVal,
	output logic      bitTgl
);
	import acr_pkg::*;

	acr_link_t link_ff;
	acr_link_t nxt_link;

	// bit is held until the next edge, long after the toggle has crossed
	always_comb begin
		nxt_link = link_ff;
		nxt_link.bitVal = sdaIn;
		nxt_link.bitTgl = ~link_ff.bitTgl;
	end

	// clock stands still between frames, so no state depends on idle edges
	always_ff @(posedge sclClk or posedge sys_rst) begin
		if (sys_rst) begin
			link_ff <= '0;
		end else begin
			link_ff <= nxt_link;
		end
	end

	assign bitVal = link_ff.bitVal;
	assign bitTgl = link_ff.bitTgl;

endmodule

// [pkg/acr_defs.svh]
// constants for the converter serial slave: field positions, reset values, codes, timing
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// ----------------------------------------------------------------
// configuration byte layout and reset values
// ----------------------------------------------------------------
`define ACR_CFG_BUSY        7
`define ACR_CFG_SINGLE      4
`define ACR_CFG_GAIN_HI     1
`define ACR_CFG_GAIN_LO     0
`define ACR_CFG_RESET       8'h80
`define ACR_RESULT_RESET    16'h0000
`define ACR_GAIN_RESET      2'h0

// ----------------------------------------------------------------
// result word layout
// ----------------------------------------------------------------
`define ACR_DATA_W          12
`define ACR_SIGN_BITS       4
`define ACR_RES_HI_BYTE     15:8
`define ACR_RES_LO_BYTE     7:0

// ----------------------------------------------------------------
// bus codes and byte fields
// ----------------------------------------------------------------
`define ACR_MCODE_FIELD     7:3
`define ACR_MCODE_HI        5'h01
`define ACR_ADDR_FIELD      7:1
`define ACR_RW_BIT          0
`define ACR_ADDR_BASE       7'h48
`define ACR_ADDR_ALT        7'h49
`define ACR_GC_ADDR         8'h00
`define ACR_GC_RESET        8'h06
`define ACR_GC_LATCH        8'h04
`define ACR_FILL_BYTE       8'hFF

// ----------------------------------------------------------------
// byte framing and read sequence
// ----------------------------------------------------------------
`define ACR_LAST_DATA_BIT   4'h7
`define ACR_ACK_SLOT        4'h8
`define ACR_IDX_MSB         2'h0
`define ACR_IDX_LSB         2'h1
`define ACR_IDX_CFG         2'h2
`define ACR_IDX_FILL        2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ACR_CLK_PERIOD_NS   4
`define ACR_HS_THIGH_NS     60
`define ACR_SYNC_LAT_CYC    4

`endif

// [pkg/acr_pkg.sv]
// types shared by the converter serial slave modules
`include "acr_defs.svh"

package acr_pkg;

	typedef logic [1:0] acr_gain_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WRITE,
		ST_READ,
		ST_GCALL,
		ST_SKIP
	} acr_state_t;

	typedef struct packed {
		logic bitVal;
		logic bitTgl;
	} acr_link_t;

	typedef struct packed {
		acr_state_t st;
		logic [3:0] bitCnt;
		logic [7:0] shReg;
		logic [7:0] txReg;
		logic [1:0] rdIdx;
		logic       rdFirst;
		logic       ackNow;
		logic       wrDone;
		logic       gcHit;
		logic       drvLow;
		logic       hsMode;
		logic       single;
		acr_gain_t  gain;
		logic       busy;
		logic [15:0] result;
		logic       convStart;
		logic       convAbort;
		logic       sclS1;
		logic       sclS2;
		logic       sclPrev;
		logic       sdaS1;
		logic       sdaS2;
		logic       sdaPrev;
		logic       tglS1;
		logic       tglS2;
		logic       tglPrev;
	} acr_core_t;

endpackage

// [testbench/acr_bus_master.sv]
// bus master model: start, stop and byte transfers on the open-drain bus
`timescale 1ns/1ps

module acr_bus_master (
	output logic      scl,
	output logic      sdaDrv,
	input  wire logic sdaLine
);
	logic tick;

	// ----------------------------------------
	// timebase and idle bus
	// ----------------------------------------
	// free 125 ns tick, phase unrelated to core_clk; scl moves only inside frames
	initial begin
		tick = 1'b0;
		scl <= 1'b1;
		sdaDrv <= 1'b1;
		// fractional offset keeps tick edges off every core_clk edge
		#37.3;
		forever #62.5 tick = ~tick;
	end

	// ----------------------------------------
	// bus primitives
	// ----------------------------------------
	// three ticks a bit: high 125 ns keeps above the slave's 16 ns floor
	task automatic bitx(input logic b, output logic r);
		@(posedge tick) sdaDrv <= b;
		@(posedge tick) scl <= 1'b1;
		@(posedge tick) r = sdaLine;
		scl <= 1'b0;
	endtask

	// start, also used as repeated start
	task automatic start();
		@(posedge tick) sdaDrv <= 1'b1;
		@(posedge tick) scl <= 1'b1;
		@(posedge tick) sdaDrv <= 1'b0;
		@(posedge tick) scl <= 1'b0;
	endtask

	task automatic stop();
		@(posedge tick) sdaDrv <= 1'b0;
		@(posedge tick) scl <= 1'b1;
		@(posedge tick) sdaDrv <= 1'b1;
	endtask

	// msb first, then releases the line for the slave's acknowledge
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask

	// last byte is refused so the slave lets go of the line
	task automatic getByte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			b[i] = r;
		end
		bitx(last, r);
	endtask
endmodule

// [testbench/acr_i2c_slave_tb_top.sv]
// self-checking bench of the converter serial slave against an integer model
`timescale 1ns/1ps
`include "acr_defs.svh"

module acr_i2c_slave_tb_top;
	import acr_pkg::*;

	logic        core_clk;
	logic        sys_rst = 1'b0;
	logic        scl;
	logic        mstSda;
	logic        sdaLine;
	logic        sdaOut;
	logic        sdaOeN;
	logic        hsFilterEn;
	logic        convStart;
	logic        convAbort;
	logic        contMode;
	acr_gain_t   gainSel;
	logic        convDone;
	logic [11:0] convData;
	logic [31:0] rng = 32'd28;
	logic        ack;
	logic [7:0]  rb;
	int          errCount = 0;
	int          checkCount = 0;
	int          nStart = 0;
	int          nAbort = 0;
	int          mSingle = 0;
	int          mBusy = 0;
	int          mGain = 0;
	int          mRes = 0;
	int          mStarts = 0;
	int          mAborts = 0;

	// open-drain data line with pull-up
	assign sdaLine = mstSda & (sdaOeN | sdaOut);

	acr_bus_master u_mst (
		.scl     (scl),
		.sdaDrv  (mstSda),
		.sdaLine (sdaLine)
	);

	acr_i2c_slave #(
		.ADDR_SEL (0)
	) u_dut (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.sclClk     (scl),
		.sclIn      (scl),
		.sdaIn      (sdaLine),
		.sdaOut     (sdaOut),
		.sdaOeN     (sdaOeN),
		.hsFilterEn (hsFilterEn),
		.convStart  (convStart),
		.convAbort  (convAbort),
		.contMode   (contMode),
		.gainSel    (gainSel),
		.convDone   (convDone),
		.convData   (convData)
	);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// converter pulses counted against the model
	always @(posedge core_clk) begin
		if (convStart === 1'b1) nStart++;
		if (convAbort === 1'b1) nAbort++;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checkCount++;
		if (got !== exp) begin
			errCount++;
			$display("unexpected value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] expByte(input int idx);
		int cfg;
		cfg = ((mSingle != 0 ? mBusy : 1) << 7) | (mSingle << 4) | mGain;
		if (idx == 0) return 8'(mRes >> 8);
		if (idx == 1) return 8'(mRes);
		if (idx == 2) return 8'(cfg);
		return 8'hFF;
	endfunction

	// expected bytes queued before the frame, so mid-frame model changes cannot leak in
	task automatic rdChk(input int n);
		logic [7:0] expQ[$];
		for (int i = 0; i < n; i++) expQ.push_back(expByte(i));
		u_mst.start();
		u_mst.sendByte({`ACR_ADDR_BASE, 1'b1}, ack);
		chk(16'(ack), 16'h1);
		for (int i = 0; i < n; i++) begin
			u_mst.getByte(i == n - 1, rb);
			chk(16'(rb), 16'(expQ.pop_front()));
		end
		u_mst.stop();
	endtask

	// extra byte is the inverse, so any effect of it would show
	task automatic wrCfg(input logic [7:0] b, input logic extra);
		u_mst.start();
		u_mst.sendByte({`ACR_ADDR_BASE, 1'b0}, ack);
		chk(16'(ack), 16'h1);
		u_mst.sendByte(b, ack);
		chk(16'(ack), 16'h1);
		if (extra) begin
			u_mst.sendByte(~b, ack);
			chk(16'(ack), 16'h0);
		end
		u_mst.stop();
		mSingle = b[4];
		mGain = b[1:0];
		if (b[4] && b[7]) begin
			mBusy = 1;
			mStarts++;
		end
		if (!b[4]) mBusy = 0;
		chk(16'(gainSel), 16'(mGain));
		chk(16'(contMode), 16'(!mSingle));
		chk(16'(nStart), 16'(mStarts));
	endtask

	// one-cycle done pulse; data goes random again after it
	task automatic done(input logic [11:0] d);
		@(posedge core_clk);
		convDone <= 1'b1;
		convData <= d;
		@(posedge core_clk);
		convDone <= 1'b0;
		convData <= 12'(xs());
		if (!mSingle || mBusy) begin
			mRes = d[11] ? {4'hF, d} : {4'h0, d};
			mBusy = 0;
		end
	endtask

	task automatic gcall(input logic [7:0] d, input logic expAck);
		u_mst.start();
		u_mst.sendByte(8'h00, ack);
		chk(16'(ack), 16'h1);
		u_mst.sendByte(d, ack);
		chk(16'(ack), 16'(expAck));
		u_mst.stop();
		if (d == 8'h06) begin
			mSingle = 0;
			mBusy = 0;
			mGain = 0;
			mRes = 0;
			mAborts++;
		end
		chk(16'(nAbort), 16'(mAborts));
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		// raised by nba so every async-reset process already waits for the edge
		sys_rst <= 1'b1;
		convDone <= 1'b0;
		convData <= 12'h000;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk(16'(contMode), 16'h1);
		chk(16'(hsFilterEn), 16'h0);
		rdChk(4);
		$display("test reset values done");
		for (int g = 0; g < 4; g++) begin
			wrCfg(8'(g) | (g == 2 ? 8'h80 : 8'h00), g == 3);
			rdChk(3);
		end
		$display("test gain codes done");
		for (int k = 0; k < 3; k++) begin
			done(k == 0 ? 12'h800 : (k == 1 ? 12'h7FF : 12'(xs())));
			rdChk(2);
		end
		$display("test continuous results done");
		wrCfg(8'h10, 1'b0);
		done(12'h123);
		rdChk(3);
		wrCfg(8'h92, 1'b0);
		rdChk(3);
		done(12'hABC);
		rdChk(3);
		$display("test single conversion done");
		gcall(8'h05, 1'b0);
		gcall(8'h04, 1'b1);
		gcall(8'h06, 1'b1);
		chk(16'(gainSel), 16'h0);
		rdChk(3);
		u_mst.start();
		u_mst.sendByte({`ACR_ADDR_ALT, 1'b0}, ack);
		chk(16'(ack), 16'h0);
		u_mst.stop();
		$display("test general call and address done");
		u_mst.start();
		u_mst.sendByte(8'h0D, ack);
		chk(16'(ack), 16'h1);
		chk(16'(hsFilterEn), 16'h1);
		u_mst.start();
		chk(16'(hsFilterEn), 16'h1);
		rdChk(3);
		repeat (8) @(posedge core_clk);
		chk(16'(hsFilterEn), 16'h0);
		$display("test fast mode done");
		summarize();
	end

	// watchdog sized above the expected run of about 260 us
	initial begin
		#400000;
		errCount++;
		$display("unexpected hang at %0t: got %0h expected %0h", $time, 0, 1);
		summarize();
	end
endmodule
